// [pkg/ldcb_pkg.sv]
package ldcb_pkg;
	// ==========================================
	// Register indices
	localparam logic [7:0] IDX_DEV_SEL      = 8'h07;
	localparam logic [7:0] IDX_ACTIVATE     = 8'h30;
	localparam logic [7:0] IDX_BASE0_HI     = 8'h60;
	localparam logic [7:0] IDX_BASE0_LO     = 8'h61;
	localparam logic [7:0] IDX_BASE1_HI     = 8'h62;
	localparam logic [7:0] IDX_BASE1_LO     = 8'h63;
	localparam logic [7:0] IDX_IRQ_PRI      = 8'h70;
	localparam logic [7:0] IDX_IRQ_SEC      = 8'h72;
	localparam logic [7:0] IDX_DMA_SEL      = 8'h74;
	localparam logic [7:0] IDX_BANK_LO      = 8'h30;
	// ==========================================
	// Function numbers
	localparam logic [3:0] FN_FLOPPY        = 4'h0;
	localparam logic [3:0] FN_PARALLEL      = 4'h3;
	localparam logic [3:0] FN_SERIAL1       = 4'h4;
	localparam logic [3:0] FN_SERIAL2       = 4'h5;
	localparam logic [3:0] FN_KEYBOARD      = 4'h7;
	localparam logic [3:0] FN_SMBUS         = 4'h9;
	localparam logic [3:0] FN_XBUS          = 4'h8;
	localparam logic [3:0] FN_RUNTIME       = 4'ha;
	localparam int         NUM_BANKS        = 8;
	// ==========================================
	// Reset values and fields
	localparam logic [7:0] RST_ZERO         = 8'h00;
	localparam logic [7:0] RST_IRQ_FLOPPY   = 8'h06;
	localparam logic [7:0] RST_DMA_FLOPPY   = 8'h02;
	localparam logic [7:0] RST_DMA_PARALLEL = 8'h04;
	localparam int         ACT_BIT          = 0;
	// Legal relocatable base window
	localparam logic [15:0] BASE_MIN        = 16'h0100;
	localparam logic [15:0] BASE_MAX8       = 16'h0ff8;
	localparam logic [15:0] BASE_MAX4       = 16'h0ffc;
	localparam logic [15:0] XBUS_MIN        = 16'h0000;
endpackage

// [src/ldcb_bank.sv]
`timescale 1ns/1ps
// One function's register set; unused registers are pruned by parameters
module ldcb_bank #(
	parameter logic [3:0] FN_NUM  = 4'h0,
	parameter bit         HAS_B1  = 1'b0,
	parameter bit         HAS_B0  = 1'b1,
	parameter bit         HAS_IS2 = 1'b0,
	parameter bit         HAS_DMA = 1'b0,
	parameter logic [7:0] IRQ_RST = 8'h00,
	parameter logic [7:0] DMA_RST = 8'h00
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        softRst,
	input  wire logic        wrEn,
	input  wire logic [7:0]  regIdx,
	input  wire logic [7:0]  wrData,
	input  wire logic        pwrSet,
	input  wire logic        pwrVal,
	output logic      [7:0]  rdData,
	output logic             actBit,
	output logic      [15:0] base0,
	output logic      [15:0] base1,
	output logic      [7:0]  irqPri,
	output logic      [7:0]  irqSec,
	output logic      [7:0]  dmaSel
);
	logic        act_ff;
	logic [15:0] base0_ff;
	logic [15:0] base1_ff;
	logic [7:0]  irqPri_ff;
	logic [7:0]  irqSec_ff;
	logic [7:0]  dmaSel_ff;

	// ==========================================
	// Activation, linked with power control
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			act_ff <= 1'b0;
		end else if (softRst) begin
			act_ff <= 1'b0;
		end else if (wrEn && regIdx == ldcb_pkg::IDX_ACTIVATE) begin
			act_ff <= wrData[ldcb_pkg::ACT_BIT];
		end else if (pwrSet) begin
			act_ff <= pwrVal;
		end
	end

	// ==========================================
	// Base address pairs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			base0_ff <= 16'h0000;
			base1_ff <= 16'h0000;
		end else if (softRst) begin
			base0_ff <= 16'h0000;
			base1_ff <= 16'h0000;
		end else if (wrEn) begin
			if (HAS_B0 && regIdx == ldcb_pkg::IDX_BASE0_HI) base0_ff[15:8] <= wrData;
			if (HAS_B0 && regIdx == ldcb_pkg::IDX_BASE0_LO) base0_ff[7:0] <= wrData;
			if (HAS_B1 && regIdx == ldcb_pkg::IDX_BASE1_HI) base1_ff[15:8] <= wrData;
			if (HAS_B1 && regIdx == ldcb_pkg::IDX_BASE1_LO) base1_ff[7:0] <= wrData;
		end
	end

	// ==========================================
	// Interrupt and DMA selects
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irqPri_ff <= IRQ_RST;
			irqSec_ff <= ldcb_pkg::RST_ZERO;
			dmaSel_ff <= DMA_RST;
		end else if (softRst) begin
			irqPri_ff <= IRQ_RST;
			irqSec_ff <= ldcb_pkg::RST_ZERO;
			dmaSel_ff <= DMA_RST;
		end else if (wrEn) begin
			if (regIdx == ldcb_pkg::IDX_IRQ_PRI) irqPri_ff <= wrData;
			if (HAS_IS2 && regIdx == ldcb_pkg::IDX_IRQ_SEC) irqSec_ff <= wrData;
			if (HAS_DMA && regIdx == ldcb_pkg::IDX_DMA_SEL) dmaSel_ff <= wrData;
		end
	end

	// Everything not decoded reads zero
	always_comb begin
		rdData = 8'h00;
		case (regIdx)
			ldcb_pkg::IDX_ACTIVATE: rdData = {7'h00, act_ff};
			ldcb_pkg::IDX_BASE0_HI: rdData = HAS_B0 ? base0_ff[15:8] : 8'h00;
			ldcb_pkg::IDX_BASE0_LO: rdData = HAS_B0 ? base0_ff[7:0] : 8'h00;
			ldcb_pkg::IDX_BASE1_HI: rdData = HAS_B1 ? base1_ff[15:8] : 8'h00;
			ldcb_pkg::IDX_BASE1_LO: rdData = HAS_B1 ? base1_ff[7:0] : 8'h00;
			ldcb_pkg::IDX_IRQ_PRI:  rdData = irqPri_ff;
			ldcb_pkg::IDX_IRQ_SEC:  rdData = HAS_IS2 ? irqSec_ff : 8'h00;
			ldcb_pkg::IDX_DMA_SEL:  rdData = HAS_DMA ? dmaSel_ff : 8'h00;
			default:                rdData = 8'h00;
		endcase
	end

	assign actBit = act_ff;
	assign base0  = HAS_B0 ? base0_ff : 16'h0000;
	assign base1  = HAS_B1 ? base1_ff : 16'h0000;
	assign irqPri = irqPri_ff;
	assign irqSec = HAS_IS2 ? irqSec_ff : 8'h00;
	assign dmaSel = HAS_DMA ? dmaSel_ff : 8'h00;
endmodule

// [src/ldcb_top.sv]
`timescale 1ns/1ps
module ldcb_top (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        softRst,
	input  wire logic        cfgState,
	input  wire logic        idxWr,
	input  wire logic        dataWr,
	input  wire logic        dataRd,
	input  wire logic [7:0]  hostData,
	input  wire logic [7:0]  pwrCtrl,
	input  wire logic        pwrCtrlWr,
	output logic      [7:0]  rdData,
	output logic             rdValid,
	output logic      [7:0]  devSel,
	output logic      [7:0]  regIndex,
	output logic      [7:0]  fnActive,
	output logic      [7:0]  fnPowerLink,
	output logic      [7:0]  fnDecodeOk,
	output logic      [15:0] floppyBase,
	output logic      [15:0] parallelBase,
	output logic      [15:0] serial1Base,
	output logic      [15:0] serial2Base,
	output logic      [7:0]  keyboardIrq2,
	output logic      [7:0]  floppyDma,
	output logic      [7:0]  parallelDma,
	output logic             irqActiveHigh,
	output logic             irqEdgeMode
);
	// ==========================================
	// Bank table: slot to function number
	localparam logic [3:0] SLOT_FN [8] = '{ldcb_pkg::FN_FLOPPY, ldcb_pkg::FN_PARALLEL,
		ldcb_pkg::FN_SERIAL1, ldcb_pkg::FN_SERIAL2, ldcb_pkg::FN_KEYBOARD,
		ldcb_pkg::FN_XBUS, ldcb_pkg::FN_SMBUS, ldcb_pkg::FN_RUNTIME};

	logic [7:0] idx_ff;
	logic [7:0] devSel_ff;
	logic [7:0] rdData_ff;
	logic       rdValid_ff;
	logic [7:0] bankWr;
	logic [7:0] bankRd [8];
	logic [7:0] bankAct;
	logic [15:0] bankBase0 [8];
	logic [15:0] bankBase1 [8];
	logic [7:0] bankIrq2 [8];
	logic [7:0] bankDma [8];
	logic [2:0] selSlot;
	logic       selHit;
	logic       bankIdx;
	logic       cfgWr;
	logic [7:0] nxt_rdData;

	// Port cycles only count inside configuration state
	assign cfgWr   = cfgState && dataWr;
	assign bankIdx = idx_ff >= ldcb_pkg::IDX_BANK_LO;

	// ==========================================
	// Index port
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			idx_ff <= 8'h00;
		end else if (cfgState && idxWr) begin
			idx_ff <= hostData;
		end
	end

	// ==========================================
	// Function number register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			devSel_ff <= 8'h00;
		end else if (softRst) begin
			devSel_ff <= 8'h00;
		end else if (cfgWr && idx_ff == ldcb_pkg::IDX_DEV_SEL) begin
			devSel_ff <= hostData;
		end
	end

	// Map function number to slot; unknown numbers hit nothing
	always_comb begin
		selSlot = 3'd0;
		selHit  = 1'b0;
		for (int i = 0; i < ldcb_pkg::NUM_BANKS; i++) begin
			if (devSel_ff == {4'h0, SLOT_FN[i]}) begin
				selSlot = 3'(i);
				selHit  = 1'b1;
			end
		end
	end

	always_comb begin
		bankWr = 8'h00;
		if (cfgWr && bankIdx && selHit) bankWr[selSlot] = 1'b1;
	end

	// ==========================================
	// Banks
	ldcb_bank #(.FN_NUM(ldcb_pkg::FN_FLOPPY), .HAS_DMA(1'b1),
		.IRQ_RST(ldcb_pkg::RST_IRQ_FLOPPY), .DMA_RST(ldcb_pkg::RST_DMA_FLOPPY)) u_floppy (
		.mclk(mclk), .rst_n(rst_n), .softRst(softRst), .wrEn(bankWr[0]), .regIdx(idx_ff),
		.wrData(hostData), .pwrSet(pwrCtrlWr), .pwrVal(pwrCtrl[0]), .rdData(bankRd[0]),
		.actBit(bankAct[0]), .base0(bankBase0[0]), .base1(bankBase1[0]),
		.irqPri(), .irqSec(bankIrq2[0]), .dmaSel(bankDma[0]));
	ldcb_bank #(.FN_NUM(ldcb_pkg::FN_PARALLEL), .HAS_DMA(1'b1),
		.DMA_RST(ldcb_pkg::RST_DMA_PARALLEL)) u_parallel (
		.mclk(mclk), .rst_n(rst_n), .softRst(softRst), .wrEn(bankWr[1]), .regIdx(idx_ff),
		.wrData(hostData), .pwrSet(pwrCtrlWr), .pwrVal(pwrCtrl[3]), .rdData(bankRd[1]),
		.actBit(bankAct[1]), .base0(bankBase0[1]), .base1(bankBase1[1]),
		.irqPri(), .irqSec(bankIrq2[1]), .dmaSel(bankDma[1]));
	ldcb_bank #(.FN_NUM(ldcb_pkg::FN_SERIAL1)) u_serial1 (
		.mclk(mclk), .rst_n(rst_n), .softRst(softRst), .wrEn(bankWr[2]), .regIdx(idx_ff),
		.wrData(hostData), .pwrSet(pwrCtrlWr), .pwrVal(pwrCtrl[4]), .rdData(bankRd[2]),
		.actBit(bankAct[2]), .base0(bankBase0[2]), .base1(bankBase1[2]),
		.irqPri(), .irqSec(bankIrq2[2]), .dmaSel(bankDma[2]));
	ldcb_bank #(.FN_NUM(ldcb_pkg::FN_SERIAL2)) u_serial2 (
		.mclk(mclk), .rst_n(rst_n), .softRst(softRst), .wrEn(bankWr[3]), .regIdx(idx_ff),
		.wrData(hostData), .pwrSet(pwrCtrlWr), .pwrVal(pwrCtrl[5]), .rdData(bankRd[3]),
		.actBit(bankAct[3]), .base0(bankBase0[3]), .base1(bankBase1[3]),
		.irqPri(), .irqSec(bankIrq2[3]), .dmaSel(bankDma[3]));
	// Keyboard sits at fixed addresses, so no base pair
	ldcb_bank #(.FN_NUM(ldcb_pkg::FN_KEYBOARD), .HAS_B0(1'b0), .HAS_IS2(1'b1)) u_keyboard (
		.mclk(mclk), .rst_n(rst_n), .softRst(softRst), .wrEn(bankWr[4]), .regIdx(idx_ff),
		.wrData(hostData), .pwrSet(1'b0), .pwrVal(1'b0), .rdData(bankRd[4]),
		.actBit(bankAct[4]), .base0(bankBase0[4]), .base1(bankBase1[4]),
		.irqPri(), .irqSec(bankIrq2[4]), .dmaSel(bankDma[4]));
	ldcb_bank #(.FN_NUM(ldcb_pkg::FN_XBUS)) u_xbus (
		.mclk(mclk), .rst_n(rst_n), .softRst(softRst), .wrEn(bankWr[5]), .regIdx(idx_ff),
		.wrData(hostData), .pwrSet(1'b0), .pwrVal(1'b0), .rdData(bankRd[5]),
		.actBit(bankAct[5]), .base0(bankBase0[5]), .base1(bankBase1[5]),
		.irqPri(), .irqSec(bankIrq2[5]), .dmaSel(bankDma[5]));
	ldcb_bank #(.FN_NUM(ldcb_pkg::FN_SMBUS)) u_smbus (
		.mclk(mclk), .rst_n(rst_n), .softRst(softRst), .wrEn(bankWr[6]), .regIdx(idx_ff),
		.wrData(hostData), .pwrSet(1'b0), .pwrVal(1'b0), .rdData(bankRd[6]),
		.actBit(bankAct[6]), .base0(bankBase0[6]), .base1(bankBase1[6]),
		.irqPri(), .irqSec(bankIrq2[6]), .dmaSel(bankDma[6]));
	ldcb_bank #(.FN_NUM(ldcb_pkg::FN_RUNTIME)) u_runtime (
		.mclk(mclk), .rst_n(rst_n), .softRst(softRst), .wrEn(bankWr[7]), .regIdx(idx_ff),
		.wrData(hostData), .pwrSet(1'b0), .pwrVal(1'b0), .rdData(bankRd[7]),
		.actBit(bankAct[7]), .base0(bankBase0[7]), .base1(bankBase1[7]),
		.irqPri(), .irqSec(bankIrq2[7]), .dmaSel(bankDma[7]));

	// ==========================================
	// Read path
	always_comb begin
		nxt_rdData = 8'h00;
		if (idx_ff == ldcb_pkg::IDX_DEV_SEL) begin
			nxt_rdData = devSel_ff;
		end else if (bankIdx && selHit) begin
			nxt_rdData = bankRd[selSlot];
		end
	end

	// Read data is registered; no answer outside configuration state
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_ff  <= 8'h00;
			rdValid_ff <= 1'b0;
		end else begin
			rdValid_ff <= cfgState && dataRd;
			if (cfgState && dataRd) rdData_ff <= nxt_rdData;
		end
	end

	// ==========================================
	// Enables and address range checks
	logic [7:0] okRange;
	always_comb begin
		okRange = 8'h00;
		okRange[0] = bankBase0[0] >= ldcb_pkg::BASE_MIN && bankBase0[0] <= ldcb_pkg::BASE_MAX8
			&& bankBase0[0][2:0] == 3'b000;
		okRange[1] = bankBase0[1] >= ldcb_pkg::BASE_MIN && bankBase0[1] <= ldcb_pkg::BASE_MAX4
			&& bankBase0[1][1:0] == 2'b00;
		okRange[2] = bankBase0[2] >= ldcb_pkg::BASE_MIN && bankBase0[2] <= ldcb_pkg::BASE_MAX8
			&& bankBase0[2][2:0] == 3'b000;
		okRange[3] = bankBase0[3] >= ldcb_pkg::BASE_MIN && bankBase0[3] <= ldcb_pkg::BASE_MAX8
			&& bankBase0[3][2:0] == 3'b000;
		okRange[4] = 1'b1;
		// Other functions' windows are not checked; they always pass
		okRange[5] = 1'b1;
		okRange[6] = 1'b1;
		okRange[7] = 1'b1;
	end

	// Power bits only exist for floppy, parallel and serial; they mirror activation
	assign fnPowerLink = {4'h0, bankAct[3:0]};
	assign fnActive    = bankAct | {4'h0, pwrCtrl[5:4], pwrCtrl[3], pwrCtrl[0]};
	assign fnDecodeOk  = fnActive & okRange;

	assign rdData        = rdData_ff;
	assign rdValid       = rdValid_ff;
	assign devSel        = devSel_ff;
	assign regIndex      = idx_ff;
	assign floppyBase    = bankBase0[0];
	assign parallelBase  = bankBase0[1];
	assign serial1Base   = bankBase0[2];
	assign serial2Base   = bankBase0[3];
	assign keyboardIrq2  = bankIrq2[4];
	assign floppyDma     = bankDma[0];
	assign parallelDma   = bankDma[1];
	// Interrupt polarity/mode are fixed at edge high
	assign irqActiveHigh = 1'b1;
	assign irqEdgeMode   = 1'b1;
endmodule

// [verification/ldcb_sva.sv]
`timescale 1ns/1ps
module ldcb_sva (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        softRst,
	input wire logic        cfgState,
	input wire logic        idxWr,
	input wire logic        dataWr,
	input wire logic        dataRd,
	input wire logic [7:0]  hostData,
	input wire logic [7:0]  pwrCtrl,
	input wire logic        pwrCtrlWr,
	input wire logic [7:0]  rdData,
	input wire logic        rdValid,
	input wire logic [7:0]  devSel,
	input wire logic [7:0]  regIndex,
	input wire logic [7:0]  fnPowerLink,
	input wire logic [15:0] floppyBase,
	input wire logic [7:0]  floppyDma,
	input wire logic        irqActiveHigh,
	input wire logic        irqEdgeMode
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// Host port
	property p_rd_ans; cfgState && dataRd |=> rdValid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_rd_off; !(cfgState && dataRd) |=> !rdValid; endproperty
	a_rd_off: assert property (p_rd_off) else $error("stray read answer");
	property p_idx; cfgState && idxWr |=> regIndex == $past(hostData); endproperty
	a_idx: assert property (p_idx) else $error("index not taken");
	property p_sel;
		cfgState && dataWr && !softRst && regIndex == 8'h07 |=> devSel == $past(hostData);
	endproperty
	a_sel: assert property (p_sel) else $error("bank select not taken");
	// Registers frozen outside configuration
	property p_hold;
		!cfgState && !softRst && !pwrCtrlWr |=>
			$stable(devSel) && $stable(regIndex) && $stable(floppyBase);
	endproperty
	a_hold: assert property (p_hold) else $error("state changed outside config");
	// ==========================================
	// Read-as-zero places, then power link, soft reset and interrupt mode
	property p_resv; cfgState && dataRd && regIndex inside {[8'h31:8'h5f]} |=> rdData == 8'h00;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved index read nonzero");
	property p_unimp;
		cfgState && dataRd && regIndex inside {8'h71, 8'h73, 8'h75, [8'h76:8'hdf]}
			|=> rdData == 8'h00;
	endproperty
	a_unimp: assert property (p_unimp) else $error("unimplemented index nonzero");
	property p_pwr;
		cfgState && pwrCtrlWr && !softRst |=> fnPowerLink[0] == $past(pwrCtrl[0]);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power bit not linked");
	property p_soft; softRst |=> devSel == 8'h00 && floppyDma == 8'h02 && floppyBase == 16'h0000;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset values wrong");
	property p_irq; irqActiveHigh && irqEdgeMode; endproperty
	a_irq: assert property (p_irq) else $error("interrupt default mode wrong");
endmodule

// [verification/ldcb_host.sv]
`timescale 1ns/1ps
module ldcb_host (
	input  wire logic       mclk,
	input  wire logic [7:0] rdData,
	input  wire logic       rdValid,
	output logic            idxWr,
	output logic            dataWr,
	output logic            dataRd,
	output logic      [7:0] hostData
);
	initial begin
		idxWr = 1'b0;
		dataWr = 1'b0;
		dataRd = 1'b0;
		hostData = 8'h00;
	end
	// Index phase always precedes the data phase
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge mclk);
		#1 idxWr = 1'b1;
		hostData = idx;
		@(posedge mclk);
		#1 idxWr = 1'b0;
		dataWr = 1'b1;
		hostData = d;
		@(posedge mclk);
		#1 dataWr = 1'b0;
		hostData = ~d;
	endtask
	// Bounded wait; ok stays low if no answer comes
	task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge mclk);
		#1 idxWr = 1'b1;
		hostData = idx;
		@(posedge mclk);
		#1 idxWr = 1'b0;
		dataRd = 1'b1;
		hostData = ~idx;
		@(posedge mclk);
		#1 dataRd = 1'b0;
		for (int n = 0; n < 4 && !ok; n++) begin
			if (rdValid === 1'b1) begin
				ok = 1'b1;
				d = rdData;
			end else begin
				@(posedge mclk);
				#1;
			end
		end
	endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        softRst = 1'b0;
	logic        cfgState = 1'b1;
	logic [7:0]  pwrCtrl = 8'h00;
	logic        pwrCtrlWr = 1'b0;
	logic        idxWr;
	logic        dataWr;
	logic        dataRd;
	logic [7:0]  hostData;
	logic [7:0]  rdData;
	logic        rdValid;
	logic [7:0]  devSel;
	logic [7:0]  fnActive;
	logic [7:0]  fnPowerLink;
	logic [7:0]  fnDecodeOk;
	logic [15:0] floppyBase;
	logic [15:0] parallelBase;
	logic [15:0] serial1Base;
	logic [15:0] serial2Base;
	logic [7:0]  parallelDma;
	logic [7:0]  keyboardIrq2;
	logic        irqActiveHigh;
	int          n_errors = 0;
	int          num_checks = 0;
	always #10 mclk = ~mclk;
	ldcb_top dut_u (.mclk, .rst_n, .softRst, .cfgState, .idxWr, .dataWr, .dataRd, .hostData,
		.pwrCtrl, .pwrCtrlWr, .rdData, .rdValid, .devSel, .regIndex(), .fnActive, .fnPowerLink,
		.fnDecodeOk, .floppyBase, .parallelBase, .serial1Base, .serial2Base, .keyboardIrq2,
		.floppyDma(), .parallelDma, .irqActiveHigh, .irqEdgeMode());
	ldcb_host host_u (.mclk, .rdData, .rdValid, .idxWr, .dataWr, .dataRd, .hostData);
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] e, input logic ok_e = 1'b1);
		logic [7:0] d;
		logic ok;
		host_u.rd(idx, d, ok);
		chk($sformatf("answer %h", idx), ok_e, ok);
		if (ok_e) chk($sformatf("reg %h", idx), e, d);
	endtask
	task automatic pulse_pwr(input logic [7:0] v);
		pwrCtrl = v;
		@(posedge mclk);
		#1 pwrCtrlWr = 1'b1;
		@(posedge mclk);
		#1 pwrCtrlWr = 1'b0;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		rdchk(8'h70, ldcb_pkg::RST_IRQ_FLOPPY);
		rdchk(8'h74, ldcb_pkg::RST_DMA_FLOPPY);
		host_u.wr(8'h07, 8'h03);
		rdchk(8'h74, ldcb_pkg::RST_DMA_PARALLEL);
		rdchk(8'h30, 8'h00);
		host_u.wr(8'h07, 8'h04);
		rdchk(8'h70, 8'h00);
		rdchk(8'h60, 8'h00);
		chk("irqHigh", 1'b1, irqActiveHigh);
	endtask
	task automatic t_act();
		host_u.wr(8'h07, 8'h03);
		host_u.wr(8'h30, 8'hff);
		rdchk(8'h30, 8'h01);
		rdchk(8'h07, 8'h03);
		chk("fnActive1", 1'b1, fnActive[1]);
		chk("link1", 1'b1, fnPowerLink[1]);
		host_u.wr(8'h30, 8'h00);
		chk("fnActive1 off", 1'b0, fnActive[1]);
	endtask
	task automatic t_resv();
		logic [7:0] lst[15] = '{8'h31, 8'h37, 8'h38, 8'h40, 8'h5f, 8'h62, 8'h6f, 8'h71,
			8'h72, 8'h73, 8'h75, 8'h76, 8'ha9, 8'he0, 8'hff};
		host_u.wr(8'h07, 8'h00);
		foreach (lst[i]) begin
			host_u.wr(lst[i], 8'hff);
			rdchk(lst[i], 8'h00);
		end
		rdchk(8'h70, ldcb_pkg::RST_IRQ_FLOPPY);
	endtask
	task automatic t_base();
		host_u.wr(8'h07, 8'h00);
		host_u.wr(8'h60, 8'h01);
		host_u.wr(8'h61, 8'h08);
		host_u.wr(8'h30, 8'h01);
		chk("floppyBase", 16'h0108, floppyBase);
		chk("decode ok", 1'b1, fnDecodeOk[0]);
		host_u.wr(8'h60, 8'h00);
		host_u.wr(8'h61, 8'h50);
		rdchk(8'h61, 8'h50);
		chk("decode bad", 1'b0, fnDecodeOk[0]);
	endtask
	task automatic t_kbd_unused();
		host_u.wr(8'h07, 8'h07);
		host_u.wr(8'h72, 8'h5a);
		rdchk(8'h72, 8'h5a);
		chk("kbdIrq2", 8'h5a, keyboardIrq2);
		host_u.wr(8'h07, 8'h01);
		host_u.wr(8'h70, 8'h0b);
		rdchk(8'h70, 8'h00);
		// Dropped write must not land in slot 0 either
		host_u.wr(8'h07, 8'h00);
		rdchk(8'h70, ldcb_pkg::RST_IRQ_FLOPPY);
		host_u.wr(8'h07, 8'h01);
	endtask
	task automatic t_nocfg();
		cfgState = 1'b0;
		host_u.wr(8'h07, 8'h03);
		rdchk(8'h07, 8'h00, 1'b0);
		chk("devSel held", 8'h01, devSel);
		cfgState = 1'b1;
	endtask
	task automatic t_pwr();
		host_u.wr(8'h07, 8'h00);
		host_u.wr(8'h30, 8'h00);
		pulse_pwr(8'h01);
		chk("pwr on", 1'b1, fnActive[0]);
		rdchk(8'h30, 8'h01);
		pulse_pwr(8'h00);
		chk("pwr off", 1'b0, fnActive[0]);
	endtask
	// Power levels alone enable; 4-byte aligned base legal only for parallel
	task automatic t_bases();
		for (int f = 3; f < 6; f++) begin
			host_u.wr(8'h07, 8'(f));
			host_u.wr(8'h60, 8'h03);
			host_u.wr(8'h61, 8'h7c);
		end
		chk("parallelBase", 16'h037c, parallelBase);
		chk("serial1Base", 16'h037c, serial1Base);
		chk("serial2Base", 16'h037c, serial2Base);
		pwrCtrl = 8'h08;
		@(posedge mclk);
		#1;
		chk("fnActive par pwr", 8'h02, fnActive);
		pwrCtrl = 8'h38;
		@(posedge mclk);
		#1;
		chk("fnActive pwr", 8'h0e, fnActive);
		chk("decode aligned", 8'h02, fnDecodeOk);
		pwrCtrl = 8'h00;
	endtask
	task automatic t_soft();
		host_u.wr(8'h07, 8'h00);
		host_u.wr(8'h60, 8'h02);
		host_u.wr(8'h74, 8'h01);
		host_u.wr(8'h07, 8'h03);
		host_u.wr(8'h74, 8'h05);
		@(posedge mclk);
		#1 softRst = 1'b1;
		@(posedge mclk);
		#1 softRst = 1'b0;
		chk("devSel soft", 8'h00, devSel);
		chk("base soft", 16'h0000, floppyBase);
		chk("parallelDma soft", ldcb_pkg::RST_DMA_PARALLEL, parallelDma);
		rdchk(8'h74, ldcb_pkg::RST_DMA_FLOPPY);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		#1 rst_n = 1'b1;
		t_reset();
		t_act();
		t_resv();
		t_base();
		t_kbd_unused();
		t_nocfg();
		t_pwr();
		t_bases();
		t_soft();
		finish_test();
	end
endmodule
bind ldcb_top ldcb_sva chk_u (.mclk, .rst_n, .softRst, .cfgState, .idxWr, .dataWr, .dataRd,
	.hostData, .pwrCtrl, .pwrCtrlWr, .rdData, .rdValid, .devSel, .regIndex, .fnPowerLink,
	.floppyBase, .floppyDma, .irqActiveHigh, .irqEdgeMode);
